// *** src/irl_pkg.sv ***
package irl_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_MHZ = 25;
  localparam int REP_PERIOD_US = 10000; // 100 Hz repeat
  localparam int REP_CYCLES = CLK_MHZ * REP_PERIOD_US;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LEVEL = 8'h04;
  localparam logic [7:0] OFS_ITYPE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_LOGHEAD = 8'h10;
  localparam logic [7:0] OFS_LOGDATA = 8'h14;
  localparam logic [7:0] OFS_IRQSTAT = 8'h18;
  localparam logic [7:0] OFS_IRQMASK = 8'h1C;
  // ctrl fields
  localparam int CTRL_CW = 0;
  localparam int CTRL_REPEAT = 1;
  localparam int CTRL_ONESHOT = 2;
  localparam int CTRL_SHOT = 4; // write-one pulse
  localparam int CTRL_ARM = 5; // write-one pulse
  // level fields
  localparam int LVL_FINE_POS = 8;
  localparam logic [5:0] COARSE_MAX = 6'h3F; // -20 - 63 = -83 dBm
  localparam logic [3:0] FINE_MAX = 4'h9; // 0.9 dB
  // log head fields
  localparam int HEAD_LOST = 31;
  localparam int HEAD_VALID = 30;
  localparam int HEAD_TYPE = 16;
  localparam int HEAD_X = 9;
  localparam int HEAD_SPI = 8;
  // irq bits
  localparam int IRQ_LOGGED = 0;
  localparam int IRQ_OVFL = 1;
  localparam int IRQ_ONESHOT = 2;
  localparam int IRQ_FIRED = 3;
  localparam int IRQ_W = 4;
  // ****************************************
  // log memory and roll-call fields
  // ****************************************
  localparam int LOG_DEPTH = 16;
  localparam int LOG_AW = 4;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [4:0] ROLLCALL_UF = 5'h04;
  localparam logic [23:0] ROLLCALL_AA = 24'h123456;
  // reply type tags
  localparam logic [1:0] RTYPE_ATCRBS = 2'h0;
  localparam logic [1:0] RTYPE_MODES = 2'h1;
  localparam logic [1:0] RTYPE_MODE4 = 2'h2;
  typedef enum logic [3:0] {
    IT_A2, IT_AB, IT_C_WIDE, IT_C_NARROW, IT_3A_WIDE, IT_3A_NARROW,
    IT_M4_TWA, IT_M4_TWB, IT_M4_TWB1, IT_MS_ALLCALL, IT_MS_ROLLCALL, IT_USER
  } irl_itype_t;
endpackage

// *** src/irl_top.sv ***
`timescale 1ns/100ps
module irl_top #(
  parameter int REP_CYCLES = irl_pkg::REP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrogation generator
  output logic tx_fire,
  output logic [3:0] tx_type,
  output logic [4:0] tx_uf,
  output logic [23:0] tx_aa,
  output logic cw_on,
  output logic [5:0] level_coarse,
  output logic [3:0] level_fine,
  // reply detector
  input wire logic rx_valid,
  input wire logic rx_timing_ok,
  input wire logic [1:0] rx_type,
  input wire logic [23:0] rx_data,
  input wire logic rx_x,
  input wire logic rx_spi,
  output logic irq
);
  // ****************************************
  // bus decode
  // ****************************************
  localparam int IRL_CNTW = $clog2(REP_CYCLES + 1);
  localparam int IRL_EW = 36; // type 2, x, spi, count 8, data 24
  logic take;
  logic wr;
  logic rd;
  logic cw_en;
  logic rep_en;
  logic one_mode;
  logic armed;
  irl_pkg::irl_itype_t itype;
  logic [IRL_CNTW-1:0] rep_cnt;
  logic lost;
  logic [irl_pkg::IRQ_W-1:0] irq_stat;
  logic [irl_pkg::IRQ_W-1:0] irq_mask;
  logic [irl_pkg::IRQ_W-1:0] irq_set;
  logic [IRL_CNTW-1:0] fire_gap;
  logic [IRL_EW-1:0] mem [irl_pkg::LOG_DEPTH];
  logic [irl_pkg::LOG_AW-1:0] head;
  logic [irl_pkg::LOG_AW-1:0] tail;
  logic [irl_pkg::LOG_AW:0] cnt;
  logic [irl_pkg::LOG_AW-1:0] newest;
  logic [IRL_EW-1:0] head_e;
  logic [IRL_EW-1:0] new_e;
  logic empty;
  logic full;
  logic pop;
  logic accept;
  logic merge;
  logic push;
  logic drop;
  logic shot_req;
  logic fire_now;

  // request taken on the edge that raises ack
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = take && wb_we_i && wb_sel_i[0];
  assign rd = take && !wb_we_i;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= take; // answer one cycle after take, drops next
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // repeat and cw only stop on software clearing the bit
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cw_en <= 1'b0;
      rep_en <= 1'b0;
      one_mode <= 1'b0;
    end else if (wr && wb_adr_i == irl_pkg::OFS_CTRL) begin
      cw_en <= wb_dat_i[irl_pkg::CTRL_CW];
      rep_en <= wb_dat_i[irl_pkg::CTRL_REPEAT];
      one_mode <= wb_dat_i[irl_pkg::CTRL_ONESHOT];
    end
  end

  // fine level clamps at 0.9 dB; coarse is a 6-bit field so it never passes -83 dBm
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      level_coarse <= 6'h00;
      level_fine <= 4'h0;
    end else if (wr && wb_adr_i == irl_pkg::OFS_LEVEL) begin
      level_coarse <= wb_dat_i[5:0];
      level_fine <= (wb_dat_i[irl_pkg::LVL_FINE_POS +: 4] > irl_pkg::FINE_MAX) ?
                    irl_pkg::FINE_MAX : wb_dat_i[irl_pkg::LVL_FINE_POS +: 4];
    end
  end

  // illegal type codes are ignored, old selection kept
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      itype <= irl_pkg::IT_A2;
    end else if (wr && wb_adr_i == irl_pkg::OFS_ITYPE &&
                 wb_dat_i[3:0] <= 4'(irl_pkg::IT_USER)) begin
      itype <= irl_pkg::irl_itype_t'(wb_dat_i[3:0]);
    end
  end

  // ****************************************
  // interrogation sequencer
  // ****************************************
  assign shot_req = wr && wb_adr_i == irl_pkg::OFS_CTRL && wb_dat_i[irl_pkg::CTRL_SHOT];

  // repeat divider: one enable pulse per 10 ms
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rep_cnt <= '0;
    end else if (!rep_en || rep_cnt == IRL_CNTW'(REP_CYCLES - 1)) begin
      rep_cnt <= '0;
    end else begin
      rep_cnt <= rep_cnt + 1'b1;
    end
  end

  // cw suppresses pulsed firing entirely
  assign fire_now = !cw_en && (shot_req ||
                    (rep_en && rep_cnt == IRL_CNTW'(REP_CYCLES - 1)));

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tx_fire <= 1'b0;
      tx_type <= 4'h0;
      tx_uf <= 5'h00;
      tx_aa <= 24'h000000;
      cw_on <= 1'b0;
    end else begin
      tx_fire <= fire_now;
      tx_type <= 4'(itype);
      tx_uf <= (itype == irl_pkg::IT_MS_ROLLCALL) ? irl_pkg::ROLLCALL_UF : 5'h00;
      tx_aa <= (itype == irl_pkg::IT_MS_ROLLCALL) ? irl_pkg::ROLLCALL_AA : 24'h000000;
      cw_on <= cw_en;
    end
  end

  // ****************************************
  // reply log
  // ****************************************
  assign empty = (cnt == '0);
  assign full = (cnt == (irl_pkg::LOG_AW+1)'(irl_pkg::LOG_DEPTH));
  assign newest = tail - 1'b1;
  assign head_e = mem[head];
  assign pop = rd && wb_adr_i == irl_pkg::OFS_LOGDATA && !empty;
  // bad timing never reaches the log; one-shot needs an armed capture
  assign accept = rx_valid && rx_timing_ok && (!one_mode || armed);
  assign new_e = {rx_type, (rx_type == irl_pkg::RTYPE_ATCRBS) && rx_x,
                  (rx_type == irl_pkg::RTYPE_ATCRBS) && rx_spi,
                  8'h01, rx_data};
  // merge only into the newest entry, not saturated, not leaving now
  assign merge = accept && !empty && !(pop && cnt == 1) &&
                 mem[newest][35:32] == new_e[35:32] && mem[newest][23:0] == rx_data &&
                 mem[newest][31:24] != irl_pkg::CNT_MAX;
  assign push = accept && !merge;
  assign drop = push && full && !pop;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      armed <= 1'b0;
    end else if (wr && wb_adr_i == irl_pkg::OFS_CTRL && wb_dat_i[irl_pkg::CTRL_ARM]) begin
      armed <= 1'b1;
    end else if (accept && one_mode) begin
      armed <= 1'b0;
    end
  end

  // log memory writes: new entry at tail or count bump on newest
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[tail] <= new_e;
    end else if (merge) begin
      mem[newest][31:24] <= mem[newest][31:24] + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      head <= '0;
      tail <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        tail <= tail + 1'b1;
      end
      if (pop || drop) begin
        head <= head + 1'b1;
      end
      cnt <= cnt + (irl_pkg::LOG_AW+1)'(push && !drop) - (irl_pkg::LOG_AW+1)'(pop);
    end
  end

  // overflow marker: drop wins over the clearing pop
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lost <= 1'b0;
    end else if (drop) begin
      lost <= 1'b1;
    end else if (pop) begin
      lost <= 1'b0;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  assign irq_set[irl_pkg::IRQ_LOGGED] = accept;
  assign irq_set[irl_pkg::IRQ_OVFL] = drop;
  assign irq_set[irl_pkg::IRQ_ONESHOT] = accept && one_mode;
  assign irq_set[irl_pkg::IRQ_FIRED] = fire_now;

  // read clears; an event in the same cycle survives
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_stat <= '0;
    end else if (rd && wb_adr_i == irl_pkg::OFS_IRQSTAT) begin
      irq_stat <= irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_mask <= '0;
    end else if (wr && wb_adr_i == irl_pkg::OFS_IRQMASK) begin
      irq_mask <= wb_dat_i[irl_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask); // one cycle behind status
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // unmapped addresses answer with zero
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd) begin
      unique case (wb_adr_i)
        irl_pkg::OFS_CTRL: wb_dat_o <= {26'h0, armed, 2'h0, one_mode, rep_en, cw_en};
        irl_pkg::OFS_LEVEL: wb_dat_o <= {20'h0, level_fine, 2'h0, level_coarse};
        irl_pkg::OFS_ITYPE: wb_dat_o <= {28'h0, 4'(itype)};
        irl_pkg::OFS_STATUS: wb_dat_o <= {24'h0, 3'(cnt >> 2), cnt[1:0], lost, !empty, 1'b0};
        irl_pkg::OFS_LOGHEAD: wb_dat_o <= {lost, !empty, 12'h0, head_e[35:34], 6'h0,
                                           head_e[33], head_e[32], head_e[31:24]};
        irl_pkg::OFS_LOGDATA: wb_dat_o <= empty ? 32'h00000000 : {8'h0, head_e[23:0]};
        irl_pkg::OFS_IRQSTAT: wb_dat_o <= {28'h0, irq_stat};
        irl_pkg::OFS_IRQMASK: wb_dat_o <= {28'h0, irq_mask};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // cycles since the last pulse; saturates so a long pause never aliases a period
  always_ff @(posedge clk_sys) begin
    if (!nrst || tx_fire) begin
      fire_gap <= '0;
    end else if (fire_gap != '1) begin
      fire_gap <= fire_gap + 1'b1;
    end
  end

  // bus and sequencer
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  rollcall_id_a: assert property (itype == irl_pkg::IT_MS_ROLLCALL |=>
    tx_uf == irl_pkg::ROLLCALL_UF && tx_aa == irl_pkg::ROLLCALL_AA)
    else $error("roll-call fields missing");
  fine_clamp_a: assert property (level_fine <= irl_pkg::FINE_MAX)
    else $error("fine level above nine tenths");
  stop_quiet_a: assert property (!rep_en && !shot_req |=> !tx_fire)
    else $error("pulse fired while stopped");
  rep_hold_a: assert property (rep_en && !(wr && wb_adr_i == irl_pkg::OFS_CTRL)
                               |=> rep_en)
    else $error("repeat stopped without a stop write");
  rep_idle_a: assert property (!rep_en |=> rep_cnt == '0)
    else $error("repeat divider ran while stopped");

  // log
  pop_order_a: assert property (pop |=> head == $past(head) + 1'b1)
    else $error("read did not advance to next entry");
  drop_head_a: assert property (drop |=> head == $past(head) + 1'b1)
    else $error("overflow kept the oldest entry");
  xspi_clear_a: assert property (push && rx_type != irl_pkg::RTYPE_ATCRBS
                                 |=> mem[$past(tail)][33:32] == 2'h0)
    else $error("x or spi kept on a non-atcrbs entry");
  new_entry_a: assert property (push |=> mem[$past(tail)][31:24] == 8'h01)
    else $error("new entry count not one");
  saturate_new_a: assert property (accept && !empty &&
                                   mem[newest][35:32] == new_e[35:32] &&
                                   mem[newest][23:0] == rx_data &&
                                   mem[newest][31:24] == irl_pkg::CNT_MAX |-> push)
    else $error("saturated entry absorbed a twin");
  arm_clear_a: assert property (accept && one_mode &&
                                !(wr && wb_dat_i[irl_pkg::CTRL_ARM] &&
                                wb_adr_i == irl_pkg::OFS_CTRL) |=> !armed)
    else $error("one-shot capture stayed armed");
  empty_read_a: assert property (rd && wb_adr_i == irl_pkg::OFS_LOGDATA && empty
                                 |=> wb_dat_o == 32'h00000000)
    else $error("empty log read returned data");

  // interrupts
  oneshot_irq_a: assert property (accept && one_mode |=> irq_stat[irl_pkg::IRQ_ONESHOT])
    else $error("one-shot capture not flagged");
  irq_clear_a: assert property (rd && wb_adr_i == irl_pkg::OFS_IRQSTAT
                                |=> irq_stat == $past(irq_set))
    else $error("status read did not clear");

  // original checks

  shot_fires_a: assert property (shot_req && !cw_en |=> tx_fire)
    else $error("single shot did not fire");
  rep_period_a: assert property (rep_en && !cw_en && rep_cnt == IRL_CNTW'(REP_CYCLES - 1)
                                 |=> tx_fire ##1 (!tx_fire || $past(shot_req)))
    else $error("repeat pulse missing or stretched");
  cw_no_pulse_a: assert property (cw_on && $past(cw_on) |-> !tx_fire)
    else $error("pulse fired during cw");
  bad_reply_a: assert property (rx_valid && !rx_timing_ok && !pop && !accept
                                |=> cnt == $past(cnt) && tail == $past(tail))
    else $error("bad reply changed the log");
  one_shot_a: assert property (one_mode && !armed && rx_valid && !pop
                               |=> cnt == $past(cnt))
    else $error("unarmed one-shot logged a reply");
  log_grow_a: assert property (accept && !merge && !pop && !full
                               |=> cnt == $past(cnt) + 1'b1)
    else $error("valid reply not logged");
  merge_bump_a: assert property (merge && !push |=> mem[$past(newest)][31:24]
                                 == $past(mem[newest][31:24]) + 8'h01)
    else $error("merge did not count");
  no_wrap_a: assert property (merge |=> mem[$past(newest)][31:24] != 8'h00)
    else $error("count wrapped past max");
  overflow_mark_a: assert property (drop |=> lost && cnt == $past(cnt))
    else $error("overflow not marked");
  lost_clear_a: assert property (pop && !drop |=> !lost)
    else $error("read left overflow marker");
  irq_level_a: assert property (|(irq_stat & irq_mask) |=> irq)
    else $error("interrupt not raised");

  merge_c: cover property (merge);
  drop_c: cover property (drop ##[1:20] pop);
  oneshot_c: cover property (armed && one_mode && accept);
  repeat_c: cover property (rep_en && tx_fire && fire_gap == IRL_CNTW'(REP_CYCLES - 1));
  cw_c: cover property (cw_en && shot_req);
endmodule

// *** verification/irl_xpdr.sv ***
`timescale 1ns/100ps
// ****************
// transponder stand-in
// ****************
module irl_xpdr (
  input wire logic clk_sys,
  input wire logic tx_fire,
  input wire logic cw_on,
  input wire logic [27:0] p_rep,
  input wire logic p_ok,
  output logic rx_valid,
  output logic rx_timing_ok,
  output logic [1:0] rx_type,
  output logic [23:0] rx_data,
  output logic rx_x,
  output logic rx_spi
);
  logic [3:0] dly = 4'h0;
  // known start so the idle toggling has something to invert
  initial begin
    {rx_valid, rx_timing_ok, rx_type, rx_data, rx_x, rx_spi} = 30'h0;
  end
  // reply five cycles after a pulsed interrogation; idle lines toggle
  // so a detector that ignores rx_valid sees garbage, not stale data
  always @(posedge clk_sys) begin
    rx_valid <= 1'b0;
    rx_timing_ok <= ~rx_timing_ok;
    {rx_type, rx_data, rx_x, rx_spi} <= ~{rx_type, rx_data, rx_x, rx_spi};
    if (dly == 4'h1) begin
      rx_valid <= 1'b1;
      rx_timing_ok <= p_ok;
      {rx_type, rx_data, rx_x, rx_spi} <= p_rep;
    end
    if (dly != 4'h0) begin
      dly <= dly - 4'h1;
    end
    if (tx_fire && !cw_on) begin
      dly <= 4'h5;
    end
  end
endmodule

// *** verification/irl_top_tb.sv ***
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module irl_top_tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic p_ok = 1'b0;
  logic armed = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, dat_o;
  logic [31:0] mode = 32'h0;
  logic ack, tx_fire, cw_on, irq, rx_valid, rx_ok, rx_x, rx_spi;
  logic [3:0] tx_type, lvl_f;
  logic [4:0] tx_uf;
  logic [23:0] tx_aa, rx_data;
  logic [5:0] lvl_c;
  logic [1:0] rx_type;
  logic [27:0] p_rep = 28'h0;
  int fails = 0;
  int num_checks = 0;
  int fires = 0;
  int cyc_n = 0;
  int seed = 88466;
  logic lost = 1'b0;
  logic [27:0] q_key[$];
  logic [7:0] q_cnt[$];
  // ****************
  // clock, counters, parts
  // ****************
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // cycle stamp and pulse tally
  always @(posedge clk_sys) begin
    cyc_n <= cyc_n + 1;
    fires <= fires + int'(tx_fire === 1'b1);
  end
  irl_top #(.REP_CYCLES(50)) dut (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .tx_fire(tx_fire), .tx_type(tx_type), .tx_uf(tx_uf),
    .tx_aa(tx_aa), .cw_on(cw_on), .level_coarse(lvl_c), .level_fine(lvl_f),
    .rx_valid(rx_valid), .rx_timing_ok(rx_ok), .rx_type(rx_type), .rx_data(rx_data),
    .rx_x(rx_x), .rx_spi(rx_spi), .irq(irq));
  irl_xpdr xpdr (.clk_sys(clk_sys), .tx_fire(tx_fire), .cw_on(cw_on), .p_rep(p_rep),
    .p_ok(p_ok), .rx_valid(rx_valid), .rx_timing_ok(rx_ok), .rx_type(rx_type),
    .rx_data(rx_data), .rx_x(rx_x), .rx_spi(rx_spi));
  // ****************
  // tasks
  // ****************
  task automatic give_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // bounded wait; reads the value held before the edge
  task automatic wait_hi(ref logic s, input int lim);
    int i;
    for (i = 0; i < lim && s !== 1'b1; i++) begin
      @(posedge clk_sys);
    end
    if (i >= lim) begin
      fails++;
      give_verdict();
    end
  endtask
  // one classic cycle, then a cycle idle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_sys);
    wait_hi(ack, 20);
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_sys);
  endtask
  // fire one shot, let the stand-in answer, update the model log
  task automatic rep(input logic [1:0] t, input logic [23:0] d, input logic x,
                     input logic s, input logic ok);
    logic [27:0] k;
    p_rep <= {t, d, x, s};
    p_ok <= ok;
    wb(1'b1, 8'h00, 32'h10 | mode);
    repeat (8) @(posedge clk_sys);
    k = {t, d, x & (t == 2'h0), s & (t == 2'h0)};
    if (!ok || (mode[2] && !armed)) return;
    armed = 1'b0;
    if (q_key.size() > 0 && q_key[$] === k && q_cnt[$] != 8'hFF) begin
      q_cnt[$]++;
    end else begin
      q_key.push_back(k);
      q_cnt.push_back(8'h01);
      if (q_key.size() > 16) begin
        void'(q_key.pop_front());
        void'(q_cnt.pop_front());
        lost = 1'b1;
      end
    end
  endtask
  // read back the whole log and compare with the model
  task automatic dump();
    logic [31:0] h;
    wb(1'b0, 8'h0C, 32'h0);
    `CHK("count", q_key.size(), rdat[7:3])
    `CHK("lost", lost, rdat[2])
    while (q_key.size() > 0) begin
      h = {lost, 1'b1, 12'h0, q_key[0][27:26], 6'h0, q_key[0][1:0], q_cnt[0]};
      wb(1'b0, 8'h10, 32'h0);
      `CHK("head", h, rdat)
      wb(1'b0, 8'h14, 32'h0);
      `CHK("data", {8'h0, q_key[0][25:2]}, rdat)
      void'(q_key.pop_front());
      void'(q_cnt.pop_front());
      lost = 1'b0;
    end
    wb(1'b0, 8'h0C, 32'h0);
    `CHK("empty", 7'h0, rdat[7:1])
    wb(1'b0, 8'h14, 32'h0);
    `CHK("empty_pop", 32'h0, rdat)
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    int n;
    int t;
    logic [31:0] r;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    wb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    `CHK("rst_lvl", 10'h0, {lvl_c, lvl_f})
    for (int i = 0; i < 13; i++) begin
      wb(1'b1, 8'h08, i);
      `CHK("itype", (i < 12) ? 4'(i) : 4'hB, tx_type)
      `CHK("uf", (i == 10) ? 5'h04 : 5'h00, tx_uf)
      `CHK("aa", (i == 10) ? 24'h123456 : 24'h0, tx_aa)
    end
    wb(1'b1, 8'h04, 32'h0F3F);
    `CHK("lvl_max", 10'h3F9, {lvl_c, lvl_f})
    wb(1'b1, 8'h04, 32'h0514);
    `CHK("lvl_mid", 10'h145, {lvl_c, lvl_f})
    // cw on first: a shot in the same write still sees the old cw state
    wb(1'b1, 8'h00, 32'h01);
    n = fires;
    wb(1'b1, 8'h00, 32'h11);
    repeat (4) @(posedge clk_sys);
    `CHK("cw_fire", n, fires)
    `CHK("cw_on", 1'b1, cw_on)
    wb(1'b1, 8'h00, 32'h00);
    wb(1'b1, 8'h00, 32'h10);
    repeat (20) @(posedge clk_sys);
    `CHK("shot", n + 1, fires)
    wb(1'b1, 8'h00, 32'h02);
    wait_hi(tx_fire, 200);
    t = cyc_n;
    @(posedge clk_sys);
    wait_hi(tx_fire, 200);
    `CHK("period", 50, cyc_n - t)
    wb(1'b1, 8'h00, 32'h00);
    n = fires;
    repeat (120) @(posedge clk_sys);
    `CHK("stopped", n, fires)
    wb(1'b0, 8'h0C, 32'h0);
    `CHK("bad_dropped", 32'h0, rdat)
    wb(1'b0, 8'h18, 32'h0);
    rep(2'h0, 24'h000001, 1'b0, 1'b0, 1'b1);
    `CHK("masked", 1'b0, irq)
    wb(1'b1, 8'h1C, 32'h1);
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      rep(2'(r[1:0] % 3), {21'h0, r[10:8]}, r[5], r[6], r[15:13] != 3'h0);
    end
    `CHK("irq", 1'b1, irq)
    wb(1'b0, 8'h18, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK("irq_clr", 1'b0, irq)
    dump();
    for (int i = 0; i < 257; i++) begin
      rep(2'h0, 24'h000777, 1'b1, 1'b1, 1'b1);
    end
    dump();
    mode = 32'h4;
    wb(1'b1, 8'h00, 32'h24);
    armed = 1'b1;
    rep(2'h1, 24'hABCDEF, 1'b1, 1'b0, 1'b1);
    rep(2'h2, 24'h000055, 1'b0, 1'b0, 1'b1);
    wb(1'b0, 8'h18, 32'h0);
    `CHK("oneshot_irq", 1'b1, rdat[2])
    dump();
    give_verdict();
  end
endmodule
